//--- hpp_fifo.sv
// Parameterised word FIFO carrying transmit words to the core side
`timescale 1ns/10ps
`default_nettype none
module hpp_fifo import hpp_pkg::*; #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("hpp_fifo depth must be a power of two");
      end
   end
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wptr;
      logic [AW:0] rptr;
   } hpp_fifo_state_t;
   hpp_fifo_state_t st, next_st;
   logic full, empty;
   assign empty = st.wptr == st.rptr;
   assign full = st.wptr == {~st.rptr[AW], st.rptr[AW-1:0]};
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = st.mem[st.rptr[AW-1:0]];
   always_comb begin
      next_st = st;
      if (in_valid && !full) begin
         next_st.mem[st.wptr[AW-1:0]] = in_data;
         next_st.wptr = st.wptr + 1'b1;
      end
      if (out_ready && !empty) begin
         next_st.rptr = st.rptr + 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st.wptr <= '0;
         st.rptr <= '0;
      end else begin
         st.wptr <= next_st.wptr;
         st.rptr <= next_st.rptr;
      end
      st.mem <= next_st.mem;
   end
   AST_FIFO_NO_OVERRUN: assert property (@(posedge mclk) disable iff (!nrst)
      full |-> ##1 (st.wptr == $past(st.wptr)) || $past(out_ready))
      else $error("fifo written while full");
endmodule // hpp_fifo
`default_nettype wire

//--- hpp_host_model.sv
// Behavioural host processor and DMA strobe source on the host pins
`timescale 1ns/10ps
`default_nettype none
module hpp_host_model (
   // Clock
   input wire logic mclk,
   // Host pins
   output logic [2:0] register_select,
   output logic read_not_write,
   output logic transfer_strobe_n,
   output logic acknowledge_n,
   output logic [7:0] host_data_in,
   input wire logic [7:0] host_data_out,
   input wire logic [7:0] host_data_oe
);
   logic drv = 1'b0;
   logic [7:0] val = 8'h00;
   logic [7:0] last = 8'h00;
   int slow = 0;
   ////////////////////////////////////////////////////////////////////////
   // Released bus never shows a stale value
   always @(posedge mclk) last <= host_data_in;
   assign host_data_in = (host_data_oe & host_data_out) |
      (~host_data_oe & (drv ? val : ~last));
   initial begin
      register_select = 3'h0;
      read_not_write = 1'b1;
      transfer_strobe_n = 1'b1;
      acknowledge_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // Strobe low and high at least four cycles, data held past the rise
   task automatic xfer(input logic [2:0] a, input logic rd,
      input logic [7:0] d, output logic [7:0] q);
      cyc(1);
      register_select = a;
      read_not_write = rd;
      val = d;
      drv = !rd;
      transfer_strobe_n = 1'b0;
      cyc(5 + slow);
      q = host_data_in;
      transfer_strobe_n = 1'b1;
      cyc(3);
      drv = 1'b0;
      cyc(2 + slow);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(a, 1'b0, d, q);
   endtask
   // Acknowledge doubles as the DMA data strobe
   task automatic ack(input logic a_n, input logic dr, input logic [7:0] d);
      cyc(1);
      val = d;
      drv = dr;
      acknowledge_n = a_n;
   endtask
endmodule // hpp_host_model
`default_nettype wire

//--- hpp_pkg.sv
// Package of constants and types for the host parallel port transmit path
package hpp_pkg;
   localparam logic [2:0] ADDR_HOST_CONTROL = 3'h0;
   localparam logic [2:0] ADDR_COMMAND_VECTOR = 3'h1;
   localparam logic [2:0] ADDR_HOST_STATUS = 3'h2;
   localparam logic [2:0] ADDR_INTERRUPT_VECTOR = 3'h3;
   localparam logic [2:0] ADDR_BYTE_HIGH = 3'h5;
   localparam logic [2:0] ADDR_BYTE_MIDDLE = 3'h6;
   localparam logic [2:0] ADDR_BYTE_LOW = 3'h7;
   // host_control fields
   localparam int CTL_RECEIVE_REQUEST_ENABLE_BIT = 0;
   localparam int CTL_TRANSMIT_REQUEST_ENABLE_BIT = 1;
   localparam int CTL_FLAG_LO = 3;
   localparam int CTL_MODE_LO = 5;
   localparam int CTL_INIT_BIT = 7;
   localparam logic [7:0] CTL_WRITE_MASK = 8'hfb;
   // command_vector fields
   localparam int CMD_PENDING_BIT = 7;
   localparam logic [5:0] RST_VECTOR_NUM = 6'h17;
   localparam logic [7:0] RST_INT_VECTOR = 8'h0f;
   // host_status bit positions
   localparam int ST_RECEIVE_FULL_FLAG_BIT = 0;
   localparam int ST_TRANSMIT_EMPTY_FLAG_BIT = 1;
   localparam int ST_TRANSMIT_READY_FLAG_BIT = 2;
   localparam int ST_FLAG_LO = 3;
   localparam int ST_DMA_BIT = 6;
   localparam int ST_REQ_BIT = 7;
   // port_control encodings
   localparam logic [1:0] PC_GPIO = 2'h0;
   localparam logic [1:0] PC_HOST = 2'h1;
   localparam logic [1:0] PC_HOST_ACK_GPIO = 2'h2;
   localparam int FIFO_DEPTH = 16;
   localparam int WORD_W = 24;
   typedef enum logic [1:0] {
      HPP_IDLE = 2'b00,
      HPP_RD = 2'b01,
      HPP_WR = 2'b11
   } hpp_strobe_t;
endpackage

//--- hpp_port.sv
// Host parallel port: host registers, transmit path, pin muxing
`timescale 1ns/10ps
`default_nettype none
module hpp_port import hpp_pkg::*; #(
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Further reset sources, one-cycle pulses
   input wire logic soft_reset,
   input wire logic stop_reset,
   // Port control from the core
   input wire logic [1:0] port_control,
   // Core side: receive word and flags
   output logic core_word_valid,
   input wire logic core_word_ready,
   output logic [WORD_W-1:0] core_side_receive_word,
   input wire logic core_receive_full_flag,
   input wire logic core_word_take,
   input wire logic core_tx_load,
   input wire logic [WORD_W-1:0] core_tx_word,
   input wire logic [1:0] core_flag_bits,
   input wire logic command_accepted,
   output logic command_pending,
   output logic [5:0] command_vector_num,
   output logic [1:0] flag_bits,
   output logic [1:0] transfer_mode_sel,
   // Host pins
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic [7:0] host_data_oe,
   input wire logic [2:0] register_select,
   input wire logic read_not_write,
   input wire logic transfer_strobe_n,
   input wire logic acknowledge_n,
   output logic service_request_n_out,
   output logic service_request_n_oe,
   // General-purpose view of the same pins
   input wire logic [14:0] gpio_out,
   input wire logic [14:0] gpio_dir,
   output logic [14:0] gpio_in
);
   initial begin
      if (DEPTH < 2) begin
         $error("hpp_port fifo depth too small");
      end
   end
   typedef struct packed {
      logic [1:0] strb_sync;
      logic [1:0] ack_sync;
      logic strb_q;
      logic ack_q;
      hpp_strobe_t phase;
      logic [2:0] addr_q;
      logic [7:0] ctl;
      logic [7:0] cvec;
      logic [1:0] hflag;
      logic [7:0] ivec;
      logic transmit_empty_flag;
      logic receive_full_flag;
      logic [WORD_W-1:0] tx;
      logic [WORD_W-1:0] rx;
      logic [7:0] dout;
   } hpp_state_t;
   hpp_state_t st, next_st;
   logic host_sel, ack_sel, dma_mode, any_reset, hard_reset;
   logic strb_fall, strb_rise, ack_fall, ack_rise, req, vec_out;
   logic [7:0] status, rd_mux;
   logic fifo_ready;
   ////////////////////////////////////////////////////////////////////////
   // Decode
   assign host_sel = port_control == PC_HOST || port_control == PC_HOST_ACK_GPIO;
   assign ack_sel = port_control == PC_HOST;
   assign dma_mode = st.ctl[CTL_MODE_LO +: 2] != 2'h0;
   // Individual reset is port control bit 0 clear with no host mode selected, i.e. PC_GPIO only
   assign any_reset = soft_reset || stop_reset || !port_control[0] && !host_sel;
   assign hard_reset = soft_reset;
   // Only second stages are looked at
   assign strb_fall = !st.strb_sync[1] && st.strb_q;
   assign strb_rise = st.strb_sync[1] && !st.strb_q;
   assign ack_fall = ack_sel && !st.ack_sync[1] && st.ack_q;
   assign ack_rise = ack_sel && st.ack_sync[1] && !st.ack_q;
   assign req = host_sel && !(ack_sel && !st.ack_sync[1] && dma_mode)
      && ((st.ctl[CTL_TRANSMIT_REQUEST_ENABLE_BIT] && st.transmit_empty_flag)
      || (st.ctl[CTL_RECEIVE_REQUEST_ENABLE_BIT] && st.receive_full_flag));
   // Vector cycle ignores every other control pin
   assign vec_out = ack_sel && req && !st.ack_sync[1] && !dma_mode;
   always_comb begin
      status = 8'h00;
      status[ST_RECEIVE_FULL_FLAG_BIT] = st.receive_full_flag;
      status[ST_TRANSMIT_EMPTY_FLAG_BIT] = st.transmit_empty_flag;
      status[ST_TRANSMIT_READY_FLAG_BIT] = st.transmit_empty_flag && !core_receive_full_flag;
      status[ST_FLAG_LO +: 2] = st.hflag;
      status[ST_DMA_BIT] = dma_mode;
      status[ST_REQ_BIT] = req;
   end
   always_comb begin
      rd_mux = 8'h00;
      if (st.addr_q == ADDR_HOST_CONTROL) begin
         rd_mux = st.ctl;
      end else if (st.addr_q == ADDR_COMMAND_VECTOR) begin
         rd_mux = st.cvec;
      end else if (st.addr_q == ADDR_HOST_STATUS) begin
         rd_mux = status;
      end else if (st.addr_q == ADDR_INTERRUPT_VECTOR) begin
         rd_mux = st.ivec;
      end else if (st.addr_q == ADDR_BYTE_HIGH) begin
         rd_mux = st.rx[23:16];
      end else if (st.addr_q == ADDR_BYTE_MIDDLE) begin
         rd_mux = st.rx[15:8];
      end else if (st.addr_q == ADDR_BYTE_LOW) begin
         rd_mux = st.rx[7:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_st = st;
      next_st.strb_sync = {st.strb_sync[0], transfer_strobe_n};
      next_st.ack_sync = {st.ack_sync[0], acknowledge_n};
      next_st.strb_q = st.strb_sync[1];
      next_st.ack_q = st.ack_sync[1];
      next_st.hflag = core_flag_bits;
      if (core_word_take) begin
         next_st.rx = core_tx_word;
      end
      if (core_tx_load) begin
         next_st.receive_full_flag = 1'b1;
      end
      if (command_accepted) begin
         next_st.cvec[CMD_PENDING_BIT] = 1'b0;
      end
      if (host_sel && !vec_out) begin
         if (strb_fall) begin
            next_st.phase = read_not_write ? HPP_RD : HPP_WR;
            next_st.addr_q = register_select;
         end else if (strb_rise) begin
            next_st.phase = HPP_IDLE;
         end
      end
      if (st.phase == HPP_RD) begin
         next_st.dout = rd_mux;
      end else if (vec_out) begin
         next_st.dout = st.ivec;
      end
      // Read of low receive byte completes on strobe release
      if (strb_rise && st.phase == HPP_RD
         && st.addr_q == ADDR_BYTE_LOW && !core_tx_load) begin
         next_st.receive_full_flag = 1'b0;
      end
      if (strb_rise && st.phase == HPP_WR) begin
         if (st.addr_q == ADDR_HOST_CONTROL) begin
            next_st.ctl = host_data_in & CTL_WRITE_MASK;
         end else if (st.addr_q == ADDR_COMMAND_VECTOR) begin
            next_st.cvec = host_data_in;
         end else if (st.addr_q == ADDR_INTERRUPT_VECTOR) begin
            next_st.ivec = host_data_in;
         end else if (st.addr_q == ADDR_BYTE_HIGH) begin
            next_st.tx[23:16] = host_data_in;
         end else if (st.addr_q == ADDR_BYTE_MIDDLE) begin
            next_st.tx[15:8] = host_data_in;
         end else if (st.addr_q == ADDR_BYTE_LOW) begin
            next_st.tx[7:0] = host_data_in;
            next_st.transmit_empty_flag = 1'b0;
         end
      end
      // DMA: acknowledge release strobes the low byte in
      if (ack_rise && dma_mode && host_sel) begin
         next_st.tx[7:0] = host_data_in;
         next_st.transmit_empty_flag = 1'b0;
      end
      // Hand-off waits for the core side to drain; the fifo absorbs bursts
      if (!st.transmit_empty_flag && !core_receive_full_flag && fifo_ready) begin
         next_st.transmit_empty_flag = 1'b1;
      end
      if (st.ctl[CTL_INIT_BIT]) begin
         next_st.transmit_empty_flag = 1'b1;
         next_st.receive_full_flag = 1'b0;
         next_st.ctl[CTL_INIT_BIT] = 1'b0;
      end
      if (any_reset) begin
         next_st.ctl = 8'h00;
         next_st.cvec = {2'h0, RST_VECTOR_NUM};
         next_st.transmit_empty_flag = 1'b1;
         next_st.receive_full_flag = 1'b0;
         next_st.phase = HPP_IDLE;
         if (hard_reset) begin
            next_st.ivec = RST_INT_VECTOR;
            next_st.hflag = 2'h0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Registers; tx and rx hold through every reset
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st.strb_sync <= 2'h3;
         st.ack_sync <= 2'h3;
         st.strb_q <= 1'b1;
         st.ack_q <= 1'b1;
         st.phase <= HPP_IDLE;
         st.addr_q <= 3'h0;
         st.ctl <= 8'h00;
         st.cvec <= {2'h0, RST_VECTOR_NUM};
         st.hflag <= 2'h0;
         st.ivec <= RST_INT_VECTOR;
         st.transmit_empty_flag <= 1'b1;
         st.receive_full_flag <= 1'b0;
         st.dout <= 8'h00;
      end else begin
         st.strb_sync <= next_st.strb_sync;
         st.ack_sync <= next_st.ack_sync;
         st.strb_q <= next_st.strb_q;
         st.ack_q <= next_st.ack_q;
         st.phase <= next_st.phase;
         st.addr_q <= next_st.addr_q;
         st.ctl <= next_st.ctl;
         st.cvec <= next_st.cvec;
         st.hflag <= next_st.hflag;
         st.ivec <= next_st.ivec;
         st.transmit_empty_flag <= next_st.transmit_empty_flag;
         st.receive_full_flag <= next_st.receive_full_flag;
         st.dout <= next_st.dout;
      end
      st.tx <= next_st.tx;
      st.rx <= next_st.rx;
   end
   ////////////////////////////////////////////////////////////////////////
   // Transmit word fifo toward core
   hpp_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
      .mclk(mclk),
      .nrst(nrst),
      .in_valid(!st.transmit_empty_flag && !core_receive_full_flag),
      .in_ready(fifo_ready),
      .in_data(st.tx),
      .out_valid(core_word_valid),
      .out_ready(core_word_ready),
      .out_data(core_side_receive_word)
   );
   ////////////////////////////////////////////////////////////////////////
   // Pins
   assign command_pending = st.cvec[CMD_PENDING_BIT];
   assign command_vector_num = st.cvec[5:0];
   assign flag_bits = st.ctl[CTL_FLAG_LO +: 2];
   assign transfer_mode_sel = st.ctl[CTL_MODE_LO +: 2];
   always_comb begin
      host_data_out = host_sel ? st.dout : gpio_out[7:0];
      host_data_oe = gpio_dir[7:0];
      if (host_sel) begin
         host_data_oe = (vec_out || (!transfer_strobe_n && read_not_write))
            ? 8'hff : 8'h00;
      end
      if (host_sel) begin
         service_request_n_out = 1'b0;
         service_request_n_oe = req;
      end else begin
         service_request_n_out = gpio_out[13];
         service_request_n_oe = gpio_dir[13];
      end
      gpio_in = {acknowledge_n, 1'b1, transfer_strobe_n, read_not_write,
         register_select, host_data_in};
   end
   AST_REQ_FOLLOWS_EMPTY: assert property (@(posedge mclk) disable iff (!nrst)
      (port_control == PC_HOST && st.ctl[CTL_TRANSMIT_REQUEST_ENABLE_BIT] && st.transmit_empty_flag
      && st.ack_sync[1]) |-> service_request_n_oe)
      else $error("request not asserted");
   AST_LOW_WRITE_CLEARS: assert property (@(posedge mclk) disable iff (!nrst)
      (strb_rise && st.phase == HPP_WR && st.addr_q == ADDR_BYTE_LOW
      && host_sel && !any_reset && !st.ctl[CTL_INIT_BIT])
      |=> !st.transmit_empty_flag || $past(!core_receive_full_flag))
      else $error("low byte write did not clear empty");
   AST_HANDOFF: assert property (@(posedge mclk) disable iff (!nrst)
      (!st.transmit_empty_flag && !core_receive_full_flag && fifo_ready) |=> st.transmit_empty_flag)
      else $error("hand-off did not set empty");
   AST_BUS_FLOAT: assert property (@(posedge mclk) disable iff (!nrst)
      (host_sel && transfer_strobe_n && !vec_out) |-> host_data_oe == 8'h00)
      else $error("bus driven without strobe");
   AST_RESET_VALUES: assert property (@(posedge mclk)
      (!nrst) |=> st.cvec == 8'h17 && st.transmit_empty_flag && !st.receive_full_flag)
      else $error("reset values wrong");
   AST_IVEC_RESET: assert property (@(posedge mclk)
      (!nrst) |=> st.ivec == RST_INT_VECTOR)
      else $error("vector not reset");
   AST_VEC_NO_DMA: assert property (@(posedge mclk) disable iff (!nrst)
      vec_out |-> !dma_mode)
      else $error("vector driven in dma mode");
   AST_GPIO_REQ: assert property (@(posedge mclk) disable iff (!nrst)
      port_control == PC_GPIO |-> service_request_n_oe == gpio_dir[13])
      else $error("request pin not plain gpio");
   AST_RX_CLEAR: assert property (@(posedge mclk) disable iff (!nrst)
      (strb_rise && st.phase == HPP_RD && st.addr_q == ADDR_BYTE_LOW
      && !core_tx_load) |=> !st.receive_full_flag)
      else $error("receive full not cleared");
endmodule // hpp_port
`default_nettype wire

//--- hpp_port_tb.sv
// Self-checking testbench for the host parallel port
`timescale 1ns/10ps
`default_nettype none
module hpp_port_tb import hpp_pkg::*;;
   logic mclk = 1'b0, nrst = 1'b0, soft_reset = 1'b0, stop_reset = 1'b0;
   logic [1:0] port_control = PC_HOST;
   logic core_word_ready = 1'b1, core_receive_full_flag = 1'b0;
   logic core_word_take = 1'b0, core_tx_load = 1'b0;
   logic [1:0] core_flag_bits = 2'h0;
   logic command_accepted = 1'b0;
   logic [WORD_W-1:0] core_tx_word = 24'h000000;
   logic [14:0] gpio_out = 15'h0000, gpio_dir = 15'h0000;
   logic core_word_valid, command_pending;
   logic service_request_n_out, service_request_n_oe;
   logic [WORD_W-1:0] core_side_receive_word;
   logic [5:0] command_vector_num;
   logic [1:0] flag_bits, transfer_mode_sel;
   logic [7:0] host_data_in, host_data_out, host_data_oe;
   logic [2:0] register_select;
   logic read_not_write, transfer_strobe_n, acknowledge_n;
   logic [14:0] gpio_in;
   logic [WORD_W-1:0] words[$];
   int n_fail = 0, num_checks = 0;
   always #20 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////
   hpp_port #(.DEPTH(FIFO_DEPTH)) DUT (.mclk, .nrst, .soft_reset,
      .stop_reset, .port_control, .core_word_valid, .core_word_ready,
      .core_side_receive_word, .core_receive_full_flag, .core_word_take,
      .core_tx_load, .core_tx_word, .core_flag_bits,
      .command_accepted, .command_pending, .command_vector_num,
      .flag_bits, .transfer_mode_sel, .host_data_in, .host_data_out,
      .host_data_oe, .register_select, .read_not_write, .transfer_strobe_n,
      .acknowledge_n, .service_request_n_out, .service_request_n_oe,
      .gpio_out, .gpio_dir, .gpio_in);
   hpp_host_model host (.mclk, .register_select, .read_not_write,
      .transfer_strobe_n, .acknowledge_n, .host_data_in, .host_data_out,
      .host_data_oe);
   always @(posedge mclk)
      if (core_word_valid === 1'b1 && core_word_ready)
         words.push_back(core_side_receive_word);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [23:0] e,
      input logic [23:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdc(input string n, input logic [2:0] a,
      input logic [7:0] e);
      logic [7:0] q;
      host.xfer(a, 1'b1, 8'h00, q);
      chk(n, {16'h0000, e}, {16'h0000, q});
   endtask
   task automatic take(input logic [23:0] e);
      chk("word", e, words.size() > 0 ? words.pop_front() : 24'hxxxxxx);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      host.cyc(1);
      s = 1'b0;
      host.cyc(2);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk("bus_oe", 24'h0, host_data_oe);
      rdc("status", ADDR_HOST_STATUS, 8'h06);
      rdc("control", ADDR_HOST_CONTROL, 8'h00);
      rdc("cmd_vec", ADDR_COMMAND_VECTOR, 8'h17);
      rdc("int_vec", ADDR_INTERRUPT_VECTOR, 8'h0f);
      rdc("unmapped", 3'h4, 8'h00);
      $display("t_reset done");
   endtask
   // Core flags show in status; accepted command drops pending
   task automatic t_core;
      core_flag_bits = 2'h3;
      host.cyc(2);
      rdc("st_flags", ADDR_HOST_STATUS, 8'h1e);
      core_flag_bits = 2'h0;
      host.wr(ADDR_COMMAND_VECTOR, 8'h85);
      chk("cmd_pend", 24'h1, command_pending);
      chk("cmd_num", 24'h05, command_vector_num);
      pulse(command_accepted);
      chk("cmd_done", 24'h0, command_pending);
      $display("t_core done");
   endtask
   task automatic t_word;
      host.wr(ADDR_BYTE_MIDDLE, 8'h34);
      host.wr(ADDR_BYTE_HIGH, 8'h12);
      host.wr(ADDR_BYTE_LOW, 8'h56);
      host.cyc(4);
      take(24'h123456);
      core_receive_full_flag = 1'b1;
      host.wr(ADDR_BYTE_LOW, 8'h77);
      rdc("st_full", ADDR_HOST_STATUS, 8'h00);
      chk("held", 24'h0, words.size());
      core_receive_full_flag = 1'b0;
      rdc("st_free", ADDR_HOST_STATUS, 8'h06);
      take(24'h123477);
      $display("t_word done");
   endtask
   // Core stalls while the buffer fills, so the last word must wait
   task automatic t_fifo;
      core_word_ready = 1'b0;
      for (int i = 0; i < 17; i++) host.wr(ADDR_BYTE_LOW, 8'(i));
      rdc("st_fifo_full", ADDR_HOST_STATUS, 8'h00);
      core_word_ready = 1'b1;
      host.cyc(40);
      for (int i = 0; i < 17; i++) take({16'h1234, 8'(i)});
      chk("valid", 24'h0, core_word_valid);
      $display("t_fifo done");
   endtask
   task automatic t_rx;
      host.slow = 3;
      core_tx_word = 24'habcdef;
      core_word_take = 1'b1;
      core_tx_load = 1'b1;
      host.cyc(1);
      core_word_take = 1'b0;
      core_tx_load = 1'b0;
      rdc("st_rx", ADDR_HOST_STATUS, 8'h07);
      rdc("rx_high", ADDR_BYTE_HIGH, 8'hab);
      rdc("st_rx_kept", ADDR_HOST_STATUS, 8'h07);
      rdc("rx_low", ADDR_BYTE_LOW, 8'hef);
      rdc("st_rx_clr", ADDR_HOST_STATUS, 8'h06);
      host.slow = 0;
      $display("t_rx done");
   endtask
   task automatic t_resets;
      host.wr(ADDR_COMMAND_VECTOR, 8'h25);
      host.wr(ADDR_INTERRUPT_VECTOR, 8'h33);
      host.wr(ADDR_HOST_CONTROL, 8'h1a);
      chk("flags", 24'h3, flag_bits);
      pulse(stop_reset);
      rdc("cv_stop", ADDR_COMMAND_VECTOR, 8'h17);
      rdc("iv_stop", ADDR_INTERRUPT_VECTOR, 8'h33);
      chk("flags_stop", 24'h0, flag_bits);
      pulse(soft_reset);
      rdc("iv_soft", ADDR_INTERRUPT_VECTOR, 8'h0f);
      rdc("rx_kept", ADDR_BYTE_HIGH, 8'hab);
      host.wr(ADDR_COMMAND_VECTOR, 8'h25);
      port_control = PC_GPIO;
      host.cyc(2);
      port_control = PC_HOST;
      rdc("cv_ind", ADDR_COMMAND_VECTOR, 8'h17);
      host.wr(ADDR_BYTE_LOW, 8'h42);
      host.cyc(4);
      take(24'h123442);
      $display("t_resets done");
   endtask
   task automatic t_request;
      host.wr(ADDR_HOST_CONTROL, 8'h02);
      chk("req_oe", 24'h1, service_request_n_oe);
      chk("req_out", 24'h0, service_request_n_out);
      rdc("st_req", ADDR_HOST_STATUS, 8'h86);
      host.ack(1'b0, 1'b0, 8'h00);
      host.cyc(4);
      chk("vec_oe", 24'hff, host_data_oe);
      chk("vec", 24'h0f, host_data_out);
      host.ack(1'b1, 1'b0, 8'h00);
      host.cyc(4);
      chk("vec_off", 24'h0, host_data_oe);
      host.wr(ADDR_HOST_CONTROL, 8'h22);
      chk("mode", 24'h1, transfer_mode_sel);
      host.ack(1'b0, 1'b1, 8'h5a);
      host.cyc(4);
      chk("dma_req", 24'h0, service_request_n_oe);
      chk("dma_oe", 24'h0, host_data_oe);
      host.ack(1'b1, 1'b1, 8'h5a);
      host.cyc(4);
      host.ack(1'b1, 1'b0, 8'h00);
      host.cyc(4);
      take(24'h12345a);
      $display("t_request done");
   endtask
   task automatic t_gpio;
      host.wr(ADDR_HOST_CONTROL, 8'h02);
      port_control = PC_HOST_ACK_GPIO;
      host.ack(1'b0, 1'b0, 8'h00);
      host.cyc(4);
      chk("ack_gpio_oe", 24'h0, host_data_oe);
      host.ack(1'b1, 1'b0, 8'h00);
      port_control = PC_GPIO;
      host.cyc(4);
      chk("gp_in", 24'h0, {service_request_n_oe, host_data_oe});
      gpio_dir = 15'h20ff;
      gpio_out = 15'h20a5;
      host.cyc(4);
      chk("gp_oe", 24'h1ff, {service_request_n_oe, host_data_oe});
      chk("gp_out", 24'h1a5, {service_request_n_out, host_data_out});
      $display("t_gpio done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      #1;
      nrst = 1'b1;
      t_reset();
      t_core();
      t_word();
      t_fifo();
      t_rx();
      t_resets();
      t_request();
      t_gpio();
      tally_and_finish();
   end
   // Whole run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      tally_and_finish();
   end
endmodule // hpp_port_tb
`default_nettype wire
